// ---- shared/seq_defs.vh ----
// register map, field layout, reset values and codes of the channel-pair sequencer
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

// -------------------------------------------------------------------
// register indices (byte address = index * 4)
// -------------------------------------------------------------------
`define IDX_CTRL         7'h02
`define IDX_CHAN_SEL     7'h03
`define IDX_STATUS       7'h04
`define IDX_STACK_INIT   7'h05
`define IDX_STACK_FIRST  7'h20
`define IDX_STACK_LAST   7'h3F
`define BANK_SEL_BIT     5

// -------------------------------------------------------------------
// fields
// -------------------------------------------------------------------
`define CTRL_STATUS_EN   0
`define CTRL_CHECK_EN    1
`define CTRL_SEQ_EN      2
`define LAYER_END_BIT    8
`define LAYER_ADDR_LSB   9
`define CTRL_RESET       3'h0
`define CHAN_SEL_RESET   8'h00

// -------------------------------------------------------------------
// select codes and fixed self-test results
// -------------------------------------------------------------------
`define SEL_SUPPLY       4'h8
`define SEL_REGULATOR    4'h9
`define SEL_SELF_TEST    4'hB
`define SELF_TEST_A      16'h2AAA
`define SELF_TEST_B      16'h1555
`define DEFAULT_PAIRS    8
`define STACK_DEPTH      32

// -------------------------------------------------------------------
// check value and bus answers
// -------------------------------------------------------------------
`define CRC_POLY         8'h07
`define CRC_INIT         8'h00
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ---- src/stack_mem.v ----
// 32-layer sequencer stack storage with registered read ports and reset defaults
`timescale 1ns/1ps
`include "seq_defs.vh"

module stack_mem (
  input  wire        aclk,
  input  wire        init,
  input  wire        wr_en,
  input  wire [4:0]  wr_addr,
  input  wire [8:0]  wr_data,
  input  wire [4:0]  bus_addr,
  output reg  [8:0]  bus_data,
  input  wire [4:0]  seq_addr,
  output reg  [8:0]  seq_data
);

  reg [8:0] layer_mem [0:`STACK_DEPTH-1];
  integer   i;

  // -------------------------------------------------------------------
  // storage: init restores pairs 0..7, last default layer ends the loop
  // -------------------------------------------------------------------
  always @(posedge aclk) begin
    if (init) begin
      for (i = 0; i < `STACK_DEPTH; i = i + 1) begin
        if (i < `DEFAULT_PAIRS)
          layer_mem[i] <= {(i == `DEFAULT_PAIRS - 1), i[3:0], i[3:0]};
        else
          layer_mem[i] <= 9'h000;
      end
    end else if (wr_en) begin
      layer_mem[wr_addr] <= wr_data;
    end
  end

  // read data come from flops, one cycle after the address
  always @(posedge aclk) begin
    bus_data <= layer_mem[bus_addr];
    seq_data <= layer_mem[seq_addr];
  end

endmodule

// ---- src/word_buffer.v ----
// two-entry skid buffer between the sequencer and the result reader
`timescale 1ns/1ps

module word_buffer #(
  parameter WIDTH = 16
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg             skid_valid;
  reg [WIDTH-1:0] skid_data;

  // a full skid slot refuses input, so a stalled reader backs up the source
  assign in_ready = ~skid_valid;

  // -------------------------------------------------------------------
  // output stage plus one spare slot
  // -------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_valid  <= 1'b0;
      out_data   <= {WIDTH{1'b0}};
      skid_valid <= 1'b0;
      skid_data  <= {WIDTH{1'b0}};
    end else begin
      if (!out_valid || out_ready) begin
        if (skid_valid) begin
          // input was refused this cycle (in_ready low), so only drain the slot
          out_valid  <= 1'b1;
          out_data   <= skid_data;
          skid_valid <= 1'b0;
        end else begin
          out_valid <= in_valid;
          out_data  <= in_data;
        end
      end else if (in_valid && !skid_valid) begin
        skid_valid <= 1'b1;
        skid_data  <= in_data;
      end
    end
  end

endmodule

// ---- src/adc_channel_pair_sequencer.v ----
// channel-pair sequencer, status word and AXI4-Lite register slave
`timescale 1ns/1ps
`include "seq_defs.vh"

// Behaviour
// - separate channel select register for single conversions
// - bank bit set: low five bits pick layer
// - each layer converts one A/B pair together
// - end flag D8 closes sequence, restart first
// - end flag clear: advance to next layer
// - B select: inputs 0-7, supply, regulator
// - code 1011 returns fixed self-test codes
// - A select in [3:0], same codes
// - layer bits [15:9] carry its address
// - reset restores pairs 0-7, others zero
// - status word read-only, writes ignored
// - status word appended after conversion words
// - status high nibbles give this pair's channel indices
// - status low byte is CRC of results
module adc_channel_pair_sequencer (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        convert_start,
  input  wire        convert_done,
  input  wire [13:0] side_a_code,
  input  wire [13:0] side_b_code,
  output reg  [3:0]  side_a_input_select,
  output reg  [3:0]  side_b_input_select,
  output reg         busy,
  output wire        result_valid,
  input  wire        result_ready,
  output wire [15:0] result_data
);

  // -------------------------------------------------------------------
  // sequencer states, one-hot
  // -------------------------------------------------------------------
  localparam [5:0] S_IDLE   = 6'b000001;
  localparam [5:0] S_FETCH  = 6'b000010;
  localparam [5:0] S_WAIT   = 6'b000100;
  localparam [5:0] S_PUSH_A = 6'b001000;
  localparam [5:0] S_PUSH_B = 6'b010000;
  localparam [5:0] S_PUSH_S = 6'b100000;

  // -------------------------------------------------------------------
  // functions
  // -------------------------------------------------------------------
  // one 16-bit word folded into the running check value, msb first
  function [7:0] crc8_word;
    input [7:0]  crc_in;
    input [15:0] word;
    integer      k;
    reg   [7:0]  c;
    begin
      c = crc_in;
      for (k = 15; k >= 0; k = k - 1) begin
        if (c[7] ^ word[k])
          c = {c[6:0], 1'b0} ^ `CRC_POLY;
        else
          c = {c[6:0], 1'b0};
      end
      crc8_word = c;
    end
  endfunction

  // result word for one side: self-test code overrides the converter
  function [15:0] side_word;
    input [3:0]  sel;
    input [13:0] code;
    input [15:0] fixed;
    begin
      if (sel == `SEL_SELF_TEST)
        side_word = fixed;
      else
        side_word = {2'b00, code};
    end
  endfunction

  // register index from a byte address; upper bits must be clear
  function [7:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = {(addr[31:9] != 23'h0), addr[8:2]};
    end
  endfunction

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  reg  [2:0]  ctrl_reg;
  reg  [7:0]  chan_sel_reg;
  reg  [15:0] status_reg;
  reg         init_reg;
  reg  [5:0]  state_reg;
  reg  [4:0]  layer_ptr_reg;
  reg         end_flag_reg;
  reg  [15:0] word_a_reg;
  reg  [15:0] word_b_reg;
  reg  [31:0] aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg  [31:0] ar_addr_reg;
  reg  [1:0]  rd_wait_reg;
  wire [8:0]  bus_rd_data;
  wire [8:0]  seq_rd_data;
  wire [7:0]  wr_idx;
  wire [7:0]  rd_idx;
  wire        wr_fire;
  wire        wr_is_layer;
  wire        rd_is_layer;
  wire        buf_in_ready;
  reg         buf_in_valid;
  reg  [15:0] buf_in_data;
  wire [15:0] lat_a;
  wire [15:0] lat_b;
  wire        append_en;

  assign wr_idx      = reg_index(aw_addr_reg);
  assign rd_idx      = reg_index(ar_addr_reg);
  assign wr_fire     = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  // bank bit set inside the stack window selects a layer by its low five bits
  assign wr_is_layer = (wr_idx[7:6] == 2'b00) && wr_idx[`BANK_SEL_BIT];
  assign rd_is_layer = (rd_idx[7:6] == 2'b00) && rd_idx[`BANK_SEL_BIT];
  assign append_en   = ctrl_reg[`CTRL_STATUS_EN] | ctrl_reg[`CTRL_CHECK_EN];

  // -------------------------------------------------------------------
  // stack storage and result buffer
  // -------------------------------------------------------------------
  stack_mem u_stack (
    .aclk     (aclk),
    .init     (init_reg),
    .wr_en    (wr_fire && wr_is_layer && (w_strb_reg[1:0] == 2'b11)),
    .wr_addr  (wr_idx[4:0]),
    .wr_data  (w_data_reg[8:0]),
    .bus_addr (rd_idx[4:0]),
    .bus_data (bus_rd_data),
    .seq_addr (layer_ptr_reg),
    .seq_data (seq_rd_data)
  );

  word_buffer #(
    .WIDTH (16)
  ) u_buffer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  // -------------------------------------------------------------------
  // AXI4-Lite write channel
  // -------------------------------------------------------------------
  // address and data are taken independently; the write happens once both are held
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_addr_reg   <= 32'h0000_0000;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      ctrl_reg      <= `CTRL_RESET;
      chan_sel_reg  <= `CHAN_SEL_RESET;
      init_reg      <= 1'b1;
    end else begin
      init_reg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (wr_idx)
          {1'b0, `IDX_CTRL}: begin
            if (w_strb_reg[0])
              ctrl_reg <= w_data_reg[2:0];
          end
          {1'b0, `IDX_CHAN_SEL}: begin
            if (w_strb_reg[0])
              chan_sel_reg <= w_data_reg[7:0];
          end
          {1'b0, `IDX_STATUS}: begin
            s_axi_bresp <= `RESP_OKAY;
          end
          {1'b0, `IDX_STACK_INIT}: begin
            if (w_strb_reg[0] && w_data_reg[0])
              init_reg <= 1'b1;
          end
          default: begin
            if (!wr_is_layer)
              s_axi_bresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------
  // AXI4-Lite read channel
  // -------------------------------------------------------------------
  // two wait cycles cover the registered stack read port
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
      ar_addr_reg   <= 32'h0000_0000;
      rd_wait_reg   <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr_reg   <= s_axi_araddr;
        s_axi_arready <= 1'b0;
        rd_wait_reg   <= 2'b01;
      end else if (rd_wait_reg == 2'b01) begin
        rd_wait_reg <= 2'b10;
      end else if (rd_wait_reg == 2'b10) begin
        rd_wait_reg  <= 2'b00;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        if (rd_is_layer) begin
          // layer word shows its own address in the top bits
          s_axi_rdata <= {16'h0000, rd_idx[6:0], bus_rd_data};
        end else begin
          case (rd_idx)
            {1'b0, `IDX_CTRL}:       s_axi_rdata <= {29'h0, ctrl_reg};
            {1'b0, `IDX_CHAN_SEL}:   s_axi_rdata <= {24'h0, chan_sel_reg};
            {1'b0, `IDX_STATUS}:     s_axi_rdata <= {16'h0, status_reg};
            {1'b0, `IDX_STACK_INIT}: s_axi_rdata <= 32'h0000_0000;
            default: begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= `RESP_SLVERR;
            end
          endcase
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------
  // buffer feed
  // -------------------------------------------------------------------
  always @* begin
    buf_in_valid = 1'b0;
    buf_in_data  = 16'h0000;
    case (state_reg)
      S_PUSH_A: begin
        buf_in_valid = 1'b1;
        buf_in_data  = word_a_reg;
      end
      S_PUSH_B: begin
        buf_in_valid = 1'b1;
        buf_in_data  = word_b_reg;
      end
      S_PUSH_S: begin
        buf_in_valid = 1'b1;
        buf_in_data  = status_reg;
      end
      default: begin
        buf_in_valid = 1'b0;
        buf_in_data  = 16'h0000;
      end
    endcase
  end

  assign lat_a = side_word(side_a_input_select, side_a_code, `SELF_TEST_A);
  assign lat_b = side_word(side_b_input_select, side_b_code, `SELF_TEST_B);

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  // starts are ignored while busy; a full buffer holds the push states
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg           <= S_IDLE;
      layer_ptr_reg       <= 5'd0;
      end_flag_reg        <= 1'b0;
      side_a_input_select <= 4'h0;
      side_b_input_select <= 4'h0;
      word_a_reg          <= 16'h0000;
      word_b_reg          <= 16'h0000;
      status_reg          <= 16'h0000;
      busy                <= 1'b0;
    end else begin
      if (init_reg)
        layer_ptr_reg <= 5'd0;
      case (state_reg)
        S_IDLE: begin
          if (convert_start) begin
            busy <= 1'b1;
            if (ctrl_reg[`CTRL_SEQ_EN]) begin
              state_reg <= S_FETCH;
            end else begin
              side_a_input_select <= chan_sel_reg[3:0];
              side_b_input_select <= chan_sel_reg[7:4];
              state_reg           <= S_WAIT;
            end
          end
        end
        S_FETCH: begin
          // one layer names both sides; the pair is converted together
          side_a_input_select <= seq_rd_data[3:0];
          side_b_input_select <= seq_rd_data[7:4];
          end_flag_reg        <= seq_rd_data[`LAYER_END_BIT];
          state_reg           <= S_WAIT;
        end
        S_WAIT: begin
          if (convert_done) begin
            word_a_reg <= lat_a;
            word_b_reg <= lat_b;
            // channel indices of this pair plus check over both words
            status_reg <= {side_a_input_select, side_b_input_select,
                           crc8_word(crc8_word(`CRC_INIT, lat_a), lat_b)};
            state_reg  <= S_PUSH_A;
          end
        end
        S_PUSH_A: begin
          if (buf_in_ready)
            state_reg <= S_PUSH_B;
        end
        S_PUSH_B: begin
          if (buf_in_ready) begin
            if (ctrl_reg[`CTRL_SEQ_EN] && !init_reg) begin
              if (end_flag_reg)
                layer_ptr_reg <= 5'd0;
              else
                layer_ptr_reg <= layer_ptr_reg + 5'd1;
            end
            if (append_en) begin
              state_reg <= S_PUSH_S;
            end else begin
              state_reg <= S_IDLE;
              busy      <= 1'b0;
            end
          end
        end
        S_PUSH_S: begin
          if (buf_in_ready) begin
            state_reg <= S_IDLE;
            busy      <= 1'b0;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          busy      <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- testbench/seq_checker_assertions.sv ----
// concurrent checks on the sequencer bus, stream and select ports
`timescale 1ns/1ps
module seq_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        convert_start,
  input wire [3:0]  side_a_input_select,
  input wire [3:0]  side_b_input_select,
  input wire        busy,
  input wire        result_valid,
  input wire        result_ready,
  input wire [15:0] result_data
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // handshakes that start a transfer
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // a conversion in progress long enough for the selects to settle
  sequence conv_settled;
    busy [*4];
  endsequence

  read_latency_a: assert property (ar_taken |=> !s_axi_rvalid ##1 !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer not three cycles after address");
  write_answer_a: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer missing two cycles after handshake");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while response pending");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("new read accepted while data pending");
  start_busy_a: assert property (convert_start && !busy |=> busy)
    else $error("conversion start did not raise busy");
  select_steady_a: assert property (conv_settled |-> $stable({side_a_input_select, side_b_input_select}))
    else $error("input selects moved during a conversion");
  result_hold_a: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
    else $error("result word lost during stall");
endmodule

bind adc_channel_pair_sequencer seq_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .convert_start, .side_a_input_select,
  .side_b_input_select, .busy, .result_valid, .result_ready, .result_data);

// ---- testbench/conv_model.sv ----
// converter stand-in answering each conversion with select-derived codes
`timescale 1ns/1ps
module conv_model (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        busy,
  input  wire [3:0]  side_a_input_select,
  input  wire [3:0]  side_b_input_select,
  input  wire [7:0]  dly,
  output reg         convert_done,
  output wire [13:0] side_a_code,
  output wire [13:0] side_b_code
);
  // ----------
  // converter
  // ----------
  reg  [7:0]  cnt_reg;
  reg         armed_reg;
  wire [13:0] a_val = 14'h0100 + {10'h000, side_a_input_select};
  wire [13:0] b_val = 14'h0200 + {10'h000, side_b_input_select};

  // one done pulse per busy period, dly+1 cycles after busy rises, so the selects have settled
  always @(posedge aclk) begin
    convert_done <= 1'b0;
    if (!aresetn || !busy) begin
      cnt_reg   <= 8'h00;
      armed_reg <= 1'b1;
    end else if (armed_reg) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg == dly) begin
        convert_done <= 1'b1;
        armed_reg    <= 1'b0;
      end
    end
  end

  // codes are inverted outside the pulse so stale values never pass as results
  assign side_a_code = convert_done ? a_val : ~a_val;
  assign side_b_code = convert_done ? b_val : ~b_val;
endmodule

// ---- testbench/adc_channel_pair_sequencer_tb_top.sv ----
// self-checking bench for the channel-pair sequencer
`timescale 1ns/1ps
`include "seq_defs.vh"
module adc_channel_pair_sequencer_tb_top;
  logic        aclk = 0, aresetn = 0, convert_start = 0, result_ready = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [7:0]  dly = 8'h03;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         convert_done, busy, result_valid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [13:0] side_a_code, side_b_code;
  wire  [3:0]  side_a_input_select, side_b_input_select;
  wire  [15:0] result_data;
  int          n_mismatch = 0, num_checks = 0;

  always #4 aclk = ~aclk;

  adc_channel_pair_sequencer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .convert_start, .convert_done, .side_a_code,
    .side_b_code, .side_a_input_select, .side_b_input_select, .busy, .result_valid,
    .result_ready, .result_data);
  conv_model u_conv (.aclk, .aresetn, .busy, .side_a_input_select, .side_b_input_select, .dly,
    .convert_done, .side_a_code, .side_b_code);

  // ----------
  // helpers
  // ----------
  task print_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task hang;
    n_mismatch++;
    $display("mismatch handshake expected answer seen none");
    print_verdict;
  endtask
  task do_reset;
    aresetn <= 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
  endtask
  // write: address and data offered together, each released once taken
  task automatic wr(input [31:0] a, input [31:0] d, input [1:0] er);
    int n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n < 100);
    if (!s_axi_bvalid) hang;
    s_axi_bready <= 0;
    chk("bresp", er, s_axi_bresp);
    // let an edge pass so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask
  task automatic rd(input [31:0] a, input [31:0] e, input [1:0] er);
    int n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    s_axi_rready  <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 100);
    if (!s_axi_rvalid) hang;
    s_axi_rready <= 0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    @(posedge aclk);
  endtask
  // ready stays up between words so back-to-back words are taken every cycle
  task automatic get_w(input [15:0] e);
    int n = 0;
    result_ready <= 1;
    do begin
      @(posedge aclk);
      n++;
    end while (!result_valid && n < 200);
    if (!result_valid) hang;
    chk("result", e, result_data);
  endtask
  function automatic [15:0] word_of(input [3:0] s, input [13:0] base, input [15:0] fx);
    return (s == `SEL_SELF_TEST) ? fx : {2'b00, base + {10'h000, s}};
  endfunction
  function automatic [7:0] crc8(input [7:0] c, input [15:0] w);
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? `CRC_POLY : 8'h00);
    return c;
  endfunction
  // one conversion; hold > 0 stalls the reader that many cycles first
  task automatic conv(input [3:0] a, input [3:0] b, input st, input int hold);
    logic [15:0] wa, wb;
    wa = word_of(a, 14'h0100, `SELF_TEST_A);
    wb = word_of(b, 14'h0200, `SELF_TEST_B);
    convert_start <= 1;
    @(posedge aclk);
    convert_start <= 0;
    if (hold > 0) begin
      repeat (hold) @(posedge aclk);
      chk("stall", 2'b11, {result_valid, busy});
    end
    get_w(wa);
    chk("sel_a", a, side_a_input_select);
    chk("sel_b", b, side_b_input_select);
    get_w(wb);
    if (st) get_w({a, b, crc8(crc8(`CRC_INIT, wa), wb)});
    result_ready <= 0;
    repeat (4) @(posedge aclk);
    chk("tail", 0, {result_valid, busy});
  endtask

  // ----------
  // scenarios
  // ----------
  task t_defaults;
    for (int i = 0; i < 32; i++)
      rd(32'h80 + 4 * i, {16'h0000, 7'(32 + i), 1'(i == 7), (i < 8) ? {4'(i), 4'(i)} : 8'h00},
        `RESP_OKAY);
  endtask
  task t_access;
    rd(32'h0000_0040, 0, `RESP_SLVERR);
    wr(32'h0000_0040, 1, `RESP_SLVERR);
    wr(32'h0000_008C, 32'h0000_FFFF, `RESP_OKAY);
    rd(32'h0000_008C, 32'h0000_47FF, `RESP_OKAY);
  endtask
  task t_seq;
    logic [15:0] st;
    st = {8'hBB, crc8(crc8(`CRC_INIT, `SELF_TEST_A), `SELF_TEST_B)};
    wr(32'h0000_0080, 32'h0000_00BB, `RESP_OKAY);
    wr(32'h0000_0084, 32'h0000_0198, `RESP_OKAY);
    wr(32'h0000_0008, 32'h0000_0005, `RESP_OKAY);
    conv(4'hB, 4'hB, 1, 0);
    conv(4'h8, 4'h9, 1, 0);
    wr(32'h0000_0008, 32'h0000_0006, `RESP_OKAY);
    conv(4'hB, 4'hB, 1, 0);
    rd(32'h0000_0010, st, `RESP_OKAY);
    wr(32'h0000_0010, 32'h0000_FFFF, `RESP_OKAY);
    rd(32'h0000_0010, st, `RESP_OKAY);
  endtask
  task t_chan;
    wr(32'h0000_0008, 0, `RESP_OKAY);
    wr(32'h0000_000C, 32'h0000_0021, `RESP_OKAY);
    conv(4'h1, 4'h2, 0, 0);
  endtask
  task t_stall;
    wr(32'h0000_0014, 1, `RESP_OKAY);
    rd(32'h0000_0084, 32'h0000_4211, `RESP_OKAY);
    wr(32'h0000_0008, 32'h0000_0005, `RESP_OKAY);
    dly <= 8'h0C;
    conv(4'h0, 4'h0, 1, 30);
    dly <= 8'h03;
  endtask

  initial begin
    do_reset;
    t_defaults;
    t_access;
    do_reset;
    rd(32'h0000_008C, 32'h0000_4633, `RESP_OKAY);
    t_seq;
    t_chan;
    t_stall;
    print_verdict;
  end
endmodule
